// File: design/ucc_timer.sv
// 16-bit up counter with two capture/compare registers, AXI4-Lite slave
// assumes one 125 MHz clock; pins are asynchronous and synchronised here
// Function
// - 16-bit up counter, internal prescaled tick or external event input.
// - count_run set lets the counter run; cleared halts it.
// - External mode counts synchronised valid edges of ext_count_input.
// - Internal mode counts base clock divided by 2 to 256.
// - Overflow raises overflow_irq; overflow_stop stops counting after it.
// - Counter forced to zero asynchronously by unit disable or reset.
// - Sync clear when not running, or on compare match a with clear.
// - Mode bit 0 means capture, mode bit 1 means compare.
// - Valid capture edge latches the count, held until next capture.
// - Each capture input has its own rise/fall/both edge select.
// - Capture mode: valid capture edge raises capcomp_irq.
// - Capture registers read zero while the unit is disabled.
// - Capture colliding with count_run clear gives no interrupt.
// - Compare mode: equality on a count tick raises capcomp_irq.
// - Match a sets, match b resets the pulse output flip-flop.
// - Writes to a capture/compare register in capture mode are ignored.
// - Compare mode capture pin raises no interrupt.
// - Pulse output is inactive level while count_run is 0.
// - Overflow stop holds zero until count_run is written 1 again.
`timescale 1ns/1ns
`include "ucc_params.svh"

module ucc_timer
	import ucc_pkg::*;
(
	// clock and reset
	input  wire logic        CORE_CLK_IN,
	input  wire logic        SYS_RST_IN,
	// AXI4-Lite write address and data
	input  wire logic [31:0] S_AXI_AWADDR_IN,
	input  wire logic        S_AXI_AWVALID_IN,
	output logic             S_AXI_AWREADY_OUT,
	input  wire logic [31:0] S_AXI_WDATA_IN,
	input  wire logic [3:0]  S_AXI_WSTRB_IN,
	input  wire logic        S_AXI_WVALID_IN,
	output logic             S_AXI_WREADY_OUT,
	// AXI4-Lite write response
	output logic [1:0]       S_AXI_BRESP_OUT,
	output logic             S_AXI_BVALID_OUT,
	input  wire logic        S_AXI_BREADY_IN,
	// AXI4-Lite read
	input  wire logic [31:0] S_AXI_ARADDR_IN,
	input  wire logic        S_AXI_ARVALID_IN,
	output logic             S_AXI_ARREADY_OUT,
	output logic [31:0]      S_AXI_RDATA_OUT,
	output logic [1:0]       S_AXI_RRESP_OUT,
	output logic             S_AXI_RVALID_OUT,
	input  wire logic        S_AXI_RREADY_IN,
	// external pins
	input  wire logic        EXT_COUNT_INPUT_IN,
	input  wire logic        EXT_CLEAR_INPUT_IN,
	input  wire logic        CAPTURE_INPUT_A_IN,
	input  wire logic        CAPTURE_INPUT_B_IN,
	// events and pulse output
	output logic             OVERFLOW_IRQ_OUT,
	output logic             CAPCOMP_IRQ_A_OUT,
	output logic             CAPCOMP_IRQ_B_OUT,
	output logic             PULSE_OUT
);

	// control registers
	logic [7:0]  timer_ctrl_a, next_ctrl_a;
	logic [7:0]  timer_ctrl_b, next_ctrl_b;
	logic [7:0]  edge_select_reg, next_edge;
	ucc_word_t   main_counter, next_counter;
	ucc_word_t   capcomp_reg_a, next_cc_a;
	ucc_word_t   capcomp_reg_b, next_cc_b;
	logic [7:0]  prescale, next_prescale;
	logic        ovf_hold, next_ovf_hold;
	logic        pulse_ff, next_pulse_ff, next_pulse_pin;
	logic        next_ovf_irq, next_irq_a, next_irq_b;

	// bus state
	logic        next_awready, next_bvalid, next_arready, next_rvalid;
	logic [1:0]  next_bresp, next_rresp;
	logic [31:0] next_rdata, rd_word;
	logic        rd_hit, wr_hit, wr_take, wr_ctrl_a;

	// pin synchronisers: 0 count, 1 clear, 2 capture a, 3 capture b
	logic [3:0]  pin_raw, pin_s1, pin_s2, pin_s3, pin_edge;

	logic        unit_en, unit_rst, count_run, tick;
	logic        match_a, match_b, run_clearing;

	assign unit_en   = timer_ctrl_a[`UCC_A_UNIT_EN];
	assign count_run = timer_ctrl_a[`UCC_A_RUN];
	// timer registers and pin synchronisers, not timer_ctrl_a or the bus, held in asynchronous reset while disabled
	assign unit_rst  = SYS_RST_IN | ~unit_en;
	assign pin_raw   = {CAPTURE_INPUT_B_IN, CAPTURE_INPUT_A_IN,
		EXT_CLEAR_INPUT_IN, EXT_COUNT_INPUT_IN};

	// per-pin synchroniser and edge selector
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_pin
			ucc_edge_t sel;
			assign sel = ucc_edge_t'(edge_select_reg[2*gi +: 2]);
			always_ff @(posedge CORE_CLK_IN or posedge unit_rst) begin
				if (unit_rst) begin
					pin_s1[gi] <= 1'b0;
					pin_s2[gi] <= 1'b0;
					pin_s3[gi] <= 1'b0;
				end else begin
					pin_s1[gi] <= pin_raw[gi];
					pin_s2[gi] <= pin_s1[gi];
					pin_s3[gi] <= pin_s2[gi];
				end
			end
			always_comb begin
				unique case (sel)
					UCC_EDGE_FALL: pin_edge[gi] = ~pin_s2[gi] & pin_s3[gi];
					UCC_EDGE_RISE: pin_edge[gi] = pin_s2[gi] & ~pin_s3[gi];
					default:       pin_edge[gi] = pin_s2[gi] ^ pin_s3[gi];
				endcase
			end
		end
	endgenerate

	// count tick: prescaler terminal count or external edge
	always_comb begin
		if (timer_ctrl_b[`UCC_B_EXT_CLK])
			tick = pin_edge[0];
		else
			tick = &(prescale | ~((8'h02 <<
				timer_ctrl_a[`UCC_A_PSC_HI:`UCC_A_PSC_LO]) - 8'h01));
	end

	assign match_a = tick & timer_ctrl_b[`UCC_B_MODE_A]
		& (main_counter == capcomp_reg_a);
	assign match_b = tick & timer_ctrl_b[`UCC_B_MODE_B]
		& (main_counter == capcomp_reg_b);

	// AXI4-Lite decode; write waits until address and data both offered
	assign wr_take = S_AXI_AWVALID_IN & S_AXI_WVALID_IN
		& ~S_AXI_AWREADY_OUT & ~S_AXI_BVALID_OUT;
	assign wr_ctrl_a = wr_take & S_AXI_WSTRB_IN[0]
		& (S_AXI_AWADDR_IN == `UCC_OFS_CTRL_A);
	assign run_clearing = wr_ctrl_a & count_run
		& ~S_AXI_WDATA_IN[`UCC_A_RUN];

	always_comb begin
		wr_hit = 1'b1;
		unique case (S_AXI_AWADDR_IN)
			`UCC_OFS_COUNT, `UCC_OFS_CC_A, `UCC_OFS_CC_B,
			`UCC_OFS_CTRL_A, `UCC_OFS_CTRL_B, `UCC_OFS_EDGE: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
		rd_hit  = 1'b1;
		rd_word = 32'h00000000;
		unique case (S_AXI_ARADDR_IN)
			`UCC_OFS_COUNT:  rd_word = {16'h0000, main_counter};
			// disabled unit reads zero through its reset as well
			`UCC_OFS_CC_A:   rd_word = {16'h0000,
				unit_en ? capcomp_reg_a : 16'h0000};
			`UCC_OFS_CC_B:   rd_word = {16'h0000,
				unit_en ? capcomp_reg_b : 16'h0000};
			`UCC_OFS_CTRL_A: rd_word = {24'h000000, timer_ctrl_a};
			`UCC_OFS_CTRL_B: rd_word = {24'h000000, timer_ctrl_b};
			`UCC_OFS_EDGE:   rd_word = {24'h000000, edge_select_reg};
			default:         rd_hit  = 1'b0;
		endcase
	end

	always_comb begin
		next_awready = wr_take;
		next_bvalid  = S_AXI_BVALID_OUT;
		next_bresp   = S_AXI_BRESP_OUT;
		if (wr_take) begin
			next_bvalid = 1'b1;
			next_bresp  = wr_hit ? `UCC_RESP_OKAY : `UCC_RESP_SLVERR;
		end else if (S_AXI_BVALID_OUT && S_AXI_BREADY_IN) begin
			next_bvalid = 1'b0;
		end
		next_arready = S_AXI_ARVALID_IN & ~S_AXI_ARREADY_OUT
			& ~S_AXI_RVALID_OUT;
		next_rvalid  = S_AXI_RVALID_OUT;
		next_rdata   = S_AXI_RDATA_OUT;
		next_rresp   = S_AXI_RRESP_OUT;
		if (next_arready) begin
			next_rvalid = 1'b1;
			next_rdata  = rd_word;
			next_rresp  = rd_hit ? `UCC_RESP_OKAY : `UCC_RESP_SLVERR;
		end else if (S_AXI_RVALID_OUT && S_AXI_RREADY_IN) begin
			next_rvalid = 1'b0;
		end
	end

	always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			S_AXI_AWREADY_OUT <= 1'b0;
			S_AXI_WREADY_OUT  <= 1'b0;
			S_AXI_BVALID_OUT  <= 1'b0;
			S_AXI_BRESP_OUT   <= `UCC_RESP_OKAY;
			S_AXI_ARREADY_OUT <= 1'b0;
			S_AXI_RVALID_OUT  <= 1'b0;
			S_AXI_RDATA_OUT   <= 32'h00000000;
			S_AXI_RRESP_OUT   <= `UCC_RESP_OKAY;
			timer_ctrl_a      <= `UCC_RST_CTRL_A;
		end else begin
			S_AXI_AWREADY_OUT <= next_awready;
			S_AXI_WREADY_OUT  <= next_awready;
			S_AXI_BVALID_OUT  <= next_bvalid;
			S_AXI_BRESP_OUT   <= next_bresp;
			S_AXI_ARREADY_OUT <= next_arready;
			S_AXI_RVALID_OUT  <= next_rvalid;
			S_AXI_RDATA_OUT   <= next_rdata;
			S_AXI_RRESP_OUT   <= next_rresp;
			timer_ctrl_a      <= next_ctrl_a;
		end
	end

	// timer next state
	always_comb begin
		next_ctrl_a    = timer_ctrl_a;
		next_ctrl_b    = timer_ctrl_b;
		next_edge      = edge_select_reg;
		next_counter   = main_counter;
		next_cc_a      = capcomp_reg_a;
		next_cc_b      = capcomp_reg_b;
		next_prescale  = prescale + 8'h01;
		next_ovf_hold  = ovf_hold;
		next_ovf_irq   = 1'b0;
		next_irq_a     = 1'b0;
		next_irq_b     = 1'b0;
		next_pulse_ff  = pulse_ff;

		// unit enable alone: other bits are dead while it is clear
		if (wr_ctrl_a) begin
			next_ctrl_a = unit_en ? S_AXI_WDATA_IN[7:0]
				: {7'h00, S_AXI_WDATA_IN[`UCC_A_UNIT_EN]};
			if (S_AXI_WDATA_IN[`UCC_A_RUN])
				next_ovf_hold = 1'b0;
		end
		if (wr_take && S_AXI_WSTRB_IN[0]
				&& S_AXI_AWADDR_IN == `UCC_OFS_CTRL_B)
			next_ctrl_b = S_AXI_WDATA_IN[7:0];
		if (wr_take && S_AXI_WSTRB_IN[0]
				&& S_AXI_AWADDR_IN == `UCC_OFS_EDGE)
			next_edge = S_AXI_WDATA_IN[7:0];
		// counter register has no write path at all
		if (wr_take && &S_AXI_WSTRB_IN[1:0] && timer_ctrl_b[`UCC_B_MODE_A]
				&& S_AXI_AWADDR_IN == `UCC_OFS_CC_A)
			next_cc_a = S_AXI_WDATA_IN[15:0];
		if (wr_take && &S_AXI_WSTRB_IN[1:0] && timer_ctrl_b[`UCC_B_MODE_B]
				&& S_AXI_AWADDR_IN == `UCC_OFS_CC_B)
			next_cc_b = S_AXI_WDATA_IN[15:0];

		// captures run off the pin edge, not the count tick
		if (!timer_ctrl_b[`UCC_B_MODE_A] && pin_edge[2]
				&& !run_clearing) begin
			next_cc_a  = main_counter;
			next_irq_a = 1'b1;
		end
		if (!timer_ctrl_b[`UCC_B_MODE_B] && pin_edge[3]
				&& !run_clearing) begin
			next_cc_b  = main_counter;
			next_irq_b = 1'b1;
		end

		if (!count_run) begin
			next_counter  = `UCC_RST_COUNT;
			next_prescale = 8'h00;
			next_pulse_ff = 1'b0;
		end else if (!ovf_hold) begin
			if (timer_ctrl_b[`UCC_B_EXT_CLR] && pin_edge[1]) begin
				next_counter = `UCC_RST_COUNT;
			end else if (tick) begin
				if (match_a && timer_ctrl_b[`UCC_B_MATCH_CLR]) begin
					next_counter = `UCC_RST_COUNT;
				end else if (main_counter == `UCC_COUNT_MAX) begin
					next_counter = `UCC_RST_COUNT;
					next_ovf_irq = 1'b1;
					next_ovf_hold = timer_ctrl_b[`UCC_B_OVF_STOP];
				end else begin
					next_counter = main_counter + 16'h0001;
				end
			end
			// compare interrupts only in compare mode
			next_irq_a = next_irq_a | match_a;
			next_irq_b = next_irq_b | match_b;
			if (timer_ctrl_b[`UCC_B_OUT_EN]) begin
				// reset side wins when both match together
				if (match_b)
					next_pulse_ff = 1'b0;
				else if (match_a)
					next_pulse_ff = 1'b1;
			end
		end
		next_pulse_pin = timer_ctrl_b[`UCC_B_ACT_LVL]
			? next_pulse_ff : ~next_pulse_ff;
	end

	always_ff @(posedge CORE_CLK_IN or posedge unit_rst) begin
		if (unit_rst) begin
			timer_ctrl_b      <= `UCC_RST_CTRL_B;
			edge_select_reg   <= `UCC_RST_EDGE;
			main_counter      <= `UCC_RST_COUNT;
			capcomp_reg_a     <= `UCC_RST_CC;
			capcomp_reg_b     <= `UCC_RST_CC;
			prescale          <= 8'h00;
			ovf_hold          <= 1'b0;
			pulse_ff          <= 1'b0;
			PULSE_OUT         <= 1'b0;
			OVERFLOW_IRQ_OUT  <= 1'b0;
			CAPCOMP_IRQ_A_OUT <= 1'b0;
			CAPCOMP_IRQ_B_OUT <= 1'b0;
		end else begin
			timer_ctrl_b      <= next_ctrl_b;
			edge_select_reg   <= next_edge;
			main_counter      <= next_counter;
			capcomp_reg_a     <= next_cc_a;
			capcomp_reg_b     <= next_cc_b;
			prescale          <= next_prescale;
			ovf_hold          <= next_ovf_hold;
			pulse_ff          <= next_pulse_ff;
			PULSE_OUT         <= next_pulse_pin;
			OVERFLOW_IRQ_OUT  <= next_ovf_irq;
			CAPCOMP_IRQ_A_OUT <= next_irq_a;
			CAPCOMP_IRQ_B_OUT <= next_irq_b;
		end
	end

	// checks
	default clocking cb @(posedge CORE_CLK_IN); endclocking
	default disable iff (unit_rst);
	property p_counter_zero_idle;
		!count_run |=> main_counter == 16'h0000;
	endproperty
	a_counter_zero_idle: assert property (p_counter_zero_idle)
		else $error("counter not cleared while stopped");
	property p_count_step;
		count_run && !ovf_hold && tick && !pin_edge[1] && !match_a
			&& main_counter != 16'hffff
			|=> main_counter == $past(main_counter) + 16'h0001;
	endproperty
	a_count_step: assert property (p_count_step)
		else $error("counter did not advance on tick");
	property p_no_tick_hold;
		count_run && !tick && !pin_edge[1]
			|=> main_counter == $past(main_counter);
	endproperty
	a_no_tick_hold: assert property (p_no_tick_hold)
		else $error("counter moved without tick");
	property p_wrap;
		count_run && !ovf_hold && tick && !pin_edge[1] && !match_a
			&& main_counter == 16'hffff
			|=> main_counter == 16'h0000 && OVERFLOW_IRQ_OUT;
	endproperty
	a_wrap: assert property (p_wrap)
		else $error("overflow did not wrap or interrupt");
	property p_ovf_stop_hold;
		OVERFLOW_IRQ_OUT && timer_ctrl_b[`UCC_B_OVF_STOP] && !wr_ctrl_a
			|-> ovf_hold ##1 main_counter == 16'h0000;
	endproperty
	a_ovf_stop_hold: assert property (p_ovf_stop_hold)
		else $error("overflow stop did not hold zero");
	property p_capture;
		!timer_ctrl_b[`UCC_B_MODE_A] && pin_edge[2] && !run_clearing
			|=> capcomp_reg_a == $past(main_counter) && CAPCOMP_IRQ_A_OUT;
	endproperty
	a_capture: assert property (p_capture)
		else $error("capture a missed");
	property p_capture_write_blocked;
		!timer_ctrl_b[`UCC_B_MODE_B] && !pin_edge[3]
			|=> capcomp_reg_b == $past(capcomp_reg_b);
	endproperty
	a_capture_write_blocked: assert property (p_capture_write_blocked)
		else $error("capture register b changed without edge");
	property p_compare_irq;
		count_run && !ovf_hold && match_b |=> CAPCOMP_IRQ_B_OUT;
	endproperty
	a_compare_irq: assert property (p_compare_irq)
		else $error("compare b match gave no interrupt");
	property p_pulse_inactive;
		!count_run |=> PULSE_OUT == !timer_ctrl_b[`UCC_B_ACT_LVL]
			|| $changed(timer_ctrl_b);
	endproperty
	a_pulse_inactive: assert property (p_pulse_inactive)
		else $error("pulse output active while stopped");
	property p_pulse_set;
		count_run && !ovf_hold && timer_ctrl_b[`UCC_B_OUT_EN]
			&& match_a && !match_b |=> pulse_ff;
	endproperty
	a_pulse_set: assert property (p_pulse_set)
		else $error("match a did not set pulse");
	c_overflow: cover property (OVERFLOW_IRQ_OUT);
	c_capture_a: cover property (CAPCOMP_IRQ_A_OUT
		&& !timer_ctrl_b[`UCC_B_MODE_A]);
	c_pulse_toggle: cover property (pulse_ff ##[1:300] !pulse_ff);
endmodule // ucc_timer

// File: design/ucc_params.svh
// constants of the up counter with capture/compare unit
// included by ucc_pkg and by the top module; definitions only
`ifndef UCC_PARAMS_SVH
`define UCC_PARAMS_SVH

// register byte addresses on the AXI4-Lite bus
`define UCC_OFS_COUNT    32'h0ffff680
`define UCC_OFS_CC_A     32'h0ffff684
`define UCC_OFS_CC_B     32'h0ffff688
`define UCC_OFS_CTRL_A   32'h0ffff68c
`define UCC_OFS_CTRL_B   32'h0ffff690
`define UCC_OFS_EDGE     32'h0ffff694

// timer_ctrl_a fields
`define UCC_A_UNIT_EN    0
`define UCC_A_RUN        1
`define UCC_A_PSC_LO     4
`define UCC_A_PSC_HI     6

// timer_ctrl_b fields
`define UCC_B_MODE_A     0
`define UCC_B_MODE_B     1
`define UCC_B_EXT_CLR    2
`define UCC_B_MATCH_CLR  3
`define UCC_B_EXT_CLK    4
`define UCC_B_ACT_LVL    5
`define UCC_B_OUT_EN     6
`define UCC_B_OVF_STOP   7

// edge_select_reg field positions (two bits each)
`define UCC_E_COUNT      0
`define UCC_E_CLEAR      2
`define UCC_E_CAP_A      4
`define UCC_E_CAP_B      6

// reset values
`define UCC_RST_CTRL_A   8'h00
`define UCC_RST_CTRL_B   8'h20
`define UCC_RST_EDGE     8'h00
`define UCC_RST_COUNT    16'h0000
`define UCC_RST_CC       16'h0000

// counter limits and response codes
`define UCC_COUNT_MAX    16'hffff
`define UCC_RESP_OKAY    2'b00
`define UCC_RESP_SLVERR  2'b10

`endif

// File: design/ucc_pkg.sv
// types shared by the up counter with capture/compare unit
// assumes ucc_params.svh is on the include path
package ucc_pkg;
	`include "ucc_params.svh"

	// valid edge choice of one pin
	typedef enum logic [1:0] {
		UCC_EDGE_FALL = 2'b00,
		UCC_EDGE_RISE = 2'b01,
		UCC_EDGE_BOTH = 2'b10,
		UCC_EDGE_BTH2 = 2'b11
	} ucc_edge_t;

	typedef logic [15:0] ucc_word_t;
endpackage

// File: test/ucc_pin_model.sv
// model of the pins outside the timer: count, clear and capture inputs
// assumes the bench calls its tasks from processes on the same clock
`timescale 1ns/1ns

module ucc_pin_model (
	// clock
	input  wire logic clk_in,
	// pins
	output logic      count_out,
	output logic      clear_out,
	output logic      cap_a_out,
	output logic      cap_b_out
);
	initial begin
		count_out = 1'b0;
		clear_out = 1'b0;
		cap_a_out = 1'b0;
		cap_b_out = 1'b0;
	end

	// levels held four clocks so the two-flop synchroniser sees each one
	task automatic pulse_count(input int n);
		for (int i = 0; i < n; i++) begin
			repeat (4) @(posedge clk_in);
			count_out <= 1'b1;
			repeat (4) @(posedge clk_in);
			count_out <= 1'b0;
		end
	endtask

	// one rising and one falling edge on the clear pin
	task automatic pulse_clear;
		repeat (4) @(posedge clk_in);
		clear_out <= 1'b1;
		repeat (4) @(posedge clk_in);
		clear_out <= 1'b0;
	endtask

	task automatic set_cap(input bit b, input logic v);
		@(posedge clk_in);
		if (b)
			cap_b_out <= v;
		else
			cap_a_out <= v;
	endtask
endmodule // ucc_pin_model

// File: test/tb_up_counter_with_capture_compare.sv
// self-checking bench of the timer: AXI4-Lite master and pin model
// assumes ucc_params.svh on the include path; one 125 MHz clock
`timescale 1ns/1ns
`include "ucc_params.svh"

`define CHK(nm, e, g) begin \
	samples_checked++; \
	if ((g) !== (e)) begin \
		errors++; \
		$display("[ERR] %s exp %0h got %0h", nm, e, g); \
	end \
end

module tb_up_counter_with_capture_compare
	import ucc_pkg::*;
;
	logic        clk;
	logic        rst;
	logic [31:0] awaddr;
	logic [31:0] wdata;
	logic [31:0] araddr;
	logic [31:0] rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp;
	logic [1:0]  rresp;
	logic        awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic        cnt_pin, clr_pin, cap_a, cap_b;
	logic        ovf_irq, irq_a, irq_b, pulse;
	int          errors;
	int          samples_checked;

	ucc_timer dut_u (
		.CORE_CLK_IN(clk), .SYS_RST_IN(rst),
		.S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid),
		.S_AXI_AWREADY_OUT(awready), .S_AXI_WDATA_IN(wdata),
		.S_AXI_WSTRB_IN(wstrb), .S_AXI_WVALID_IN(wvalid),
		.S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp),
		.S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(bready),
		.S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid),
		.S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata),
		.S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid),
		.S_AXI_RREADY_IN(rready), .EXT_COUNT_INPUT_IN(cnt_pin),
		.EXT_CLEAR_INPUT_IN(clr_pin), .CAPTURE_INPUT_A_IN(cap_a),
		.CAPTURE_INPUT_B_IN(cap_b), .OVERFLOW_IRQ_OUT(ovf_irq),
		.CAPCOMP_IRQ_A_OUT(irq_a), .CAPCOMP_IRQ_B_OUT(irq_b),
		.PULSE_OUT(pulse)
	);

	ucc_pin_model pins_u (
		.clk_in(clk), .count_out(cnt_pin), .clear_out(clr_pin),
		.cap_a_out(cap_a), .cap_b_out(cap_b)
	);

	task automatic close_out;
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		bit done;
		done = 0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int i = 0; i < 50 && !done; i++) begin
			@(posedge clk);
			if (awready === 1'b1)
				awvalid <= 1'b0;
			if (wready === 1'b1)
				wvalid <= 1'b0;
			if (bvalid === 1'b1) begin
				bready <= 1'b0;
				done = 1;
				`CHK("bresp", `UCC_RESP_OKAY, bresp)
			end
		end
		if (!done) begin
			errors++;
			close_out();
		end
	endtask

	task automatic rd(input logic [31:0] a, output logic [31:0] d,
			output logic [1:0] r);
		bit done;
		done = 0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int i = 0; i < 50 && !done; i++) begin
			@(posedge clk);
			if (arready === 1'b1)
				arvalid <= 1'b0;
			if (rvalid === 1'b1) begin
				rready <= 1'b0;
				d = rdata;
				r = rresp;
				done = 1;
			end
		end
		if (!done) begin
			errors++;
			close_out();
		end
	endtask

	task automatic rchk(input logic [31:0] a, input logic [31:0] e,
			input string nm);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		`CHK(nm, e, d)
	endtask

	// cycles until the chosen irq is sampled high; lim means never
	task automatic wt(input bit b, input int lim, output int n);
		n = lim;
		for (int i = 0; i < lim; i++) begin
			@(posedge clk);
			if ((b ? irq_b : irq_a) === 1'b1) begin
				n = i;
				break;
			end
		end
	endtask

	task automatic t_reset;
		logic [31:0] d;
		logic [1:0]  r;
		rchk(`UCC_OFS_COUNT, 32'h0, "count");
		rchk(`UCC_OFS_CTRL_A, 32'h0, "ctrl_a");
		rchk(`UCC_OFS_CTRL_B, 32'h20, "ctrl_b");
		rchk(`UCC_OFS_EDGE, 32'h0, "edge");
		rd(32'h0ffff6fc, d, r);
		`CHK("unmapped resp", `UCC_RESP_SLVERR, r)
		`CHK("unmapped data", 32'h0, d)
	endtask

	task automatic t_compare;
		int n;
		wr(`UCC_OFS_CTRL_A, 32'h01);
		wr(`UCC_OFS_CTRL_B, 32'h29);
		wr(`UCC_OFS_CC_A, 32'h5);
		for (int s = 0; s < 3; s++) begin
			wr(`UCC_OFS_CTRL_A, 32'h01);
			wr(`UCC_OFS_CTRL_A, 32'h03 | (s << 4));
			wt(0, 200, n);
			wt(0, 200, n);
			`CHK("period", 6 * (2 << s), n + 1)
		end
		wr(`UCC_OFS_CTRL_A, 32'h01);
		rchk(`UCC_OFS_COUNT, 32'h0, "count stop");
		repeat (20) @(posedge clk);
		rchk(`UCC_OFS_CTRL_A, 32'h01, "ctrl_a");
		rchk(`UCC_OFS_COUNT, 32'h0, "count held");
	endtask

	task automatic t_pulse;
		int n;
		wr(`UCC_OFS_CTRL_B, 32'h63);
		wr(`UCC_OFS_CC_A, 32'h3);
		wr(`UCC_OFS_CC_B, 32'h8);
		wr(`UCC_OFS_CTRL_A, 32'h03);
		`CHK("pulse idle", 1'b0, pulse)
		wt(0, 100, n);
		repeat (2) @(posedge clk);
		`CHK("pulse set", 1'b1, pulse)
		wt(1, 100, n);
		repeat (2) @(posedge clk);
		`CHK("pulse reset", 1'b0, pulse)
		wr(`UCC_OFS_CTRL_A, 32'h01);
		wr(`UCC_OFS_CTRL_B, 32'h43);
		repeat (2) @(posedge clk);
		`CHK("pulse inactive low act", 1'b1, pulse)
	endtask

	task automatic t_capture;
		logic [31:0] d1, d2;
		logic [1:0]  r;
		int          n;
		wr(`UCC_OFS_CTRL_B, 32'h20);
		wr(`UCC_OFS_EDGE, 32'h90);
		wr(`UCC_OFS_CTRL_A, 32'h03);
		repeat (20) @(posedge clk);
		pins_u.set_cap(0, 1'b1);
		wt(0, 10, n);
		`CHK("cap a rise irq", 1'b1, n < 10)
		rd(`UCC_OFS_CC_A, d1, r);
		`CHK("cap a nonzero", 1'b1, d1 != 32'h0)
		rd(`UCC_OFS_COUNT, d2, r);
		rchk(`UCC_OFS_CC_A, d1, "cap a held");
		pins_u.set_cap(0, 1'b0);
		wt(0, 10, n);
		`CHK("cap a fall ignored", 1'b0, n < 10)
		wr(`UCC_OFS_CC_A, 32'h1234);
		rd(`UCC_OFS_COUNT, d2, r);
		rchk(`UCC_OFS_CC_A, d1, "cc a write ignored");
		pins_u.set_cap(1, 1'b1);
		wt(1, 10, n);
		`CHK("cap b rise irq", 1'b1, n < 10)
		pins_u.set_cap(1, 1'b0);
		wt(1, 10, n);
		`CHK("cap b fall irq", 1'b1, n < 10)
		wr(`UCC_OFS_CTRL_A, 32'h00);
		rchk(`UCC_OFS_CC_A, 32'h0, "cc a disabled");
		rchk(`UCC_OFS_COUNT, 32'h0, "count disabled");
		wr(`UCC_OFS_CC_A, 32'h55);
		rchk(`UCC_OFS_CTRL_B, 32'h20, "ctrl_b unit reset");
		// re-enabled so the read shows the register, not the gate
		wr(`UCC_OFS_CTRL_A, 32'h01);
		rchk(`UCC_OFS_CC_A, 32'h0, "cc a write lost");
	endtask

	task automatic t_pin_compare;
		int n;
		wr(`UCC_OFS_CTRL_A, 32'h01);
		wr(`UCC_OFS_CTRL_B, 32'h21);
		wr(`UCC_OFS_EDGE, 32'h10);
		wr(`UCC_OFS_CC_A, 32'hff00);
		rchk(`UCC_OFS_CC_A, 32'hff00, "cc a compare");
		wr(`UCC_OFS_CTRL_A, 32'h03);
		pins_u.set_cap(0, 1'b1);
		wt(0, 20, n);
		`CHK("pin irq in compare", 1'b0, n < 20)
		pins_u.set_cap(0, 1'b0);
	endtask

	task automatic t_ext;
		wr(`UCC_OFS_CTRL_A, 32'h01);
		// shared pin use: both registers in compare mode
		wr(`UCC_OFS_CTRL_B, 32'h37);
		wr(`UCC_OFS_EDGE, 32'h05);
		wr(`UCC_OFS_CTRL_A, 32'h03);
		pins_u.pulse_count(5);
		repeat (10) @(posedge clk);
		rchk(`UCC_OFS_COUNT, 32'h5, "ext count");
		rchk(`UCC_OFS_CTRL_B, 32'h37, "ctrl_b ext");
		pins_u.pulse_clear();
		repeat (10) @(posedge clk);
		rchk(`UCC_OFS_COUNT, 32'h0, "ext clear");
	endtask

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	initial begin
		rst = 1'b1;
		awaddr = 32'h0;
		wdata = 32'h0;
		araddr = 32'h0;
		wstrb = 4'hf;
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		arvalid = 1'b0;
		rready = 1'b0;
		errors = 0;
		samples_checked = 0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_compare();
		t_pulse();
		t_capture();
		t_pin_compare();
		t_ext();
		close_out();
	end
endmodule // tb_up_counter_with_capture_compare
